/* rtl/asc_start_unit.sv */
`include "asc_defines.svh"
`timescale 1ns/10ps
`default_nettype none

module asc_start_unit
    import asc_pkg::*;
(
    input wire logic i_ref_clk,
    input wire logic i_rst_b,
    input wire logic i_ce,
    input wire logic i_cmd_valid,
    input wire asc_cmd_s i_cmd,
    input wire logic [1:0] i_pos_in_use,
    input wire logic [1:0] i_home_none,
    input wire logic [1:0] i_move_done,
    input wire logic [1:0] i_move_fault,
    input wire logic [1:0] i_move_rest,
    input wire logic i_err_clear,
    output asc_motion_s [1:0] o_motion,
    output logic [1:0] o_decel_req,
    output asc_flags_s [1:0] o_flags,
    output logic o_op_error,
    output logic [15:0] o_op_error_code
);

    logic [1:0] rst_sync_q;
    logic rst_b;
    asc_state_s q;
    asc_state_s d;
    logic err_hit;
    logic [15:0] err_code;
    logic [1:0] axis_err;
    logic [1:0] go;
    logic [1:0] halt;
    asc_mv_e kind;
    logic [1:0] idx_bad;
    logic [31:0] jog_speed;

    // reset released through two stages; not frozen by the clock enable
    always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            rst_sync_q <= 2'h0;
        end else begin
            rst_sync_q <= {rst_sync_q[0], 1'b1};
        end
    end
    assign rst_b = rst_sync_q[1];

    always_comb begin
        d = q;
        err_hit = 1'b0;
        err_code = `ASC_RST_CODE;
        axis_err = 2'h0;
        go = 2'h0;
        halt = 2'h0;
        kind = ASC_MV_TABLE;
        // data number span check per axis
        idx_bad[0] = (i_cmd.word[0] < `ASC_DATA_MIN) || (i_cmd.word[0] > `ASC_DATA_MAX);
        idx_bad[1] = (i_cmd.word[1] < `ASC_DATA_MIN) || (i_cmd.word[1] > `ASC_DATA_MAX);
        // low word first; clamp to the limit
        jog_speed = {i_cmd.word[1], i_cmd.word[0]};
        if (jog_speed > `ASC_SPEED_MAX) begin
            jog_speed = `ASC_SPEED_MAX;
        end
        for (int i = 0; i < 2; i++) begin
            d.ax[i].mot.start = 1'b0;
        end
        if (i_err_clear) begin
            d.op_err = 1'b0;
        end
        if (i_cmd_valid) begin
            case (i_cmd.op)
                ASC_OP_DUAL: begin
                    kind = ASC_MV_TABLE;
                    if (!i_cmd.loc_ok) begin
                        err_hit = 1'b1;
                        err_code = `ASC_ERR_LOC;
                    // both axes must be in use
                    end else if (i_pos_in_use != 2'h3) begin
                        err_hit = 1'b1;
                        err_code = `ASC_ERR_UNUSED;
                    end else if (idx_bad != 2'h0) begin
                        err_hit = 1'b1;
                        err_code = `ASC_ERR_RANGE;
                        axis_err = idx_bad;
                    end else if (q.ax[0].st == ASC_ST_IDLE && q.ax[1].st == ASC_ST_IDLE) begin
                        go = 2'h3;
                    end
                end
                ASC_OP_HOME: begin
                    kind = (i_cmd.word[0] == `ASC_HOME_MACH) ? ASC_MV_HOME_MACH
                                                              : ASC_MV_HOME_FAST;
                    if (!i_cmd.loc_ok) begin
                        err_hit = 1'b1;
                        err_code = `ASC_ERR_LOC;
                    end else if (!i_pos_in_use[i_cmd.axis] || i_home_none[i_cmd.axis]) begin
                        err_hit = 1'b1;
                        err_code = `ASC_ERR_UNUSED;
                    // type outside 1..3 blocks the start
                    end else if (i_cmd.word[0] < `ASC_HOME_MACH
                                 || i_cmd.word[0] > `ASC_HOME_FAST_STBY) begin
                        axis_err[i_cmd.axis] = 1'b1;
                    end else if (q.ax[i_cmd.axis].st == ASC_ST_IDLE) begin
                        go[i_cmd.axis] = 1'b1;
                    end
                end
                ASC_OP_JOG: begin
                    kind = ASC_MV_JOG;
                    if (!i_cmd.loc_ok) begin
                        err_hit = 1'b1;
                        err_code = `ASC_ERR_LOC;
                    end else if (!i_pos_in_use[i_cmd.axis]) begin
                        err_hit = 1'b1;
                        err_code = `ASC_ERR_UNUSED;
                    end else if (q.ax[i_cmd.axis].st == ASC_ST_IDLE) begin
                        go[i_cmd.axis] = 1'b1;
                    end
                end
                default: begin
                    if (!i_pos_in_use[i_cmd.axis]) begin
                        err_hit = 1'b1;
                        err_code = `ASC_ERR_UNUSED;
                    end else begin
                        halt[i_cmd.axis] = 1'b1;
                    end
                end
            endcase
        end
        // set wins over a clear in the same cycle
        if (err_hit) begin
            d.op_err = 1'b1;
            d.op_code = err_code;
        end
        // every axis works on its own slice only
        for (int i = 0; i < 2; i++) begin
            if (axis_err[i]) begin
                d.ax[i].fl.err = 1'b1;
            end
            case (q.ax[i].st)
                ASC_ST_IDLE: begin
                    if (go[i]) begin
                        d.ax[i].st = ASC_ST_RUN;
                        // busy at start; done flags drop
                        d.ax[i].fl.busy = 1'b1;
                        d.ax[i].fl.pos_done = 1'b0;
                        d.ax[i].fl.home_done = 1'b0;
                        d.ax[i].fl.err = 1'b0;
                        if (kind == ASC_MV_HOME_MACH) begin
                            d.ax[i].fl.home_req = 1'b1;
                        end
                        d.ax[i].mot.start = 1'b1;
                        d.ax[i].mot.kind = kind;
                        d.ax[i].mot.data_index = i_cmd.word[i];
                        d.ax[i].mot.target = 32'h0;
                        d.ax[i].mot.speed = 32'h0;
                        d.ax[i].mot.acc = 16'h0;
                        d.ax[i].mot.dec = 16'h0;
                        d.ax[i].mot.dir = 1'b0;
                        // standby address only for type 3
                        if (i_cmd.op == ASC_OP_HOME && i_cmd.word[0] == `ASC_HOME_FAST_STBY) begin
                            d.ax[i].mot.target = {i_cmd.word[2], i_cmd.word[1]};
                        end
                        if (kind == ASC_MV_JOG) begin
                            d.ax[i].mot.speed = jog_speed;
                            d.ax[i].mot.acc = i_cmd.word[2];
                            d.ax[i].mot.dec = i_cmd.word[3];
                            d.ax[i].mot.dir = i_cmd.dir;
                        end
                    end
                end
                ASC_ST_RUN: begin
                    // halt or fault goes to deceleration
                    if (halt[i] || i_move_fault[i]) begin
                        d.ax[i].st = ASC_ST_DECEL;
                    end else if (i_move_done[i]) begin
                        // this axis finishes on its own
                        d.ax[i].st = ASC_ST_IDLE;
                        d.ax[i].fl.busy = 1'b0;
                        d.ax[i].fl.pos_done = (q.ax[i].mot.kind != ASC_MV_JOG);
                        if (q.ax[i].mot.kind == ASC_MV_HOME_MACH) begin
                            d.ax[i].fl.home_req = 1'b0;
                            d.ax[i].fl.home_done = 1'b1;
                        end
                    end
                end
                ASC_ST_DECEL: begin
                    // done flags stay clear after a stopped move
                    if (i_move_rest[i]) begin
                        d.ax[i].st = ASC_ST_IDLE;
                        d.ax[i].fl.busy = 1'b0;
                    end
                end
                default: begin
                    d.ax[i].st = ASC_ST_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge i_ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            q <= '0;
            q.ax[0].st <= ASC_ST_IDLE;
            q.ax[1].st <= ASC_ST_IDLE;
        end else if (i_ce) begin
            q <= d;
        end
    end

    always_comb begin
        for (int i = 0; i < 2; i++) begin
            o_motion[i] = q.ax[i].mot;
            o_flags[i] = q.ax[i].fl;
            o_decel_req[i] = (q.ax[i].st == ASC_ST_DECEL);
        end
    end
    assign o_op_error = q.op_err;
    assign o_op_error_code = q.op_code;

    default clocking cb @(posedge i_ref_clk);
    endclocking
    default disable iff (!rst_b);

    busy_both_set_a: assert property (i_ce && go == 2'h3 |=> o_flags[0].busy && o_flags[1].busy)
        else $error("dual start did not raise both busy flags");
    own_finish_a: assert property (i_ce && q.ax[1].st == ASC_ST_RUN && i_move_done[1] && !halt[1]
        && !i_move_fault[1] && q.ax[1].mot.kind != ASC_MV_JOG |=> !o_flags[1].busy && o_flags[1].pos_done)
        else $error("axis finish did not set done");
    done_clear_start_a: assert property (i_ce && go[0] |=> !o_flags[0].pos_done ##0 !o_flags[0].home_done)
        else $error("start left a done flag set");
    halt_no_done_a: assert property (i_ce && halt[0] && q.ax[0].st == ASC_ST_RUN
        |=> o_decel_req[0] && !o_flags[0].pos_done)
        else $error("halt did not decelerate cleanly");
    range_code_a: assert property (i_ce && i_cmd_valid && i_cmd.op == ASC_OP_DUAL && i_cmd.loc_ok
        && i_pos_in_use == 2'h3 && idx_bad != 2'h0 |=> o_op_error && o_op_error_code == 16'h1004)
        else $error("range error code not stored");
    loc_code_a: assert property (i_ce && i_cmd_valid && !i_cmd.loc_ok && i_cmd.op != ASC_OP_HALT
        |=> o_op_error && o_op_error_code == 16'h1005)
        else $error("location error code not stored");
    unused_code_a: assert property (i_ce && i_cmd_valid && i_cmd.op == ASC_OP_JOG && i_cmd.loc_ok
        && !i_pos_in_use[i_cmd.axis] |=> o_op_error && o_op_error_code == 16'h1014)
        else $error("unused axis error code not stored");
    home_req_a: assert property (i_ce && go[0] && kind == ASC_MV_HOME_MACH
        |=> o_flags[0].busy && o_flags[0].home_req && o_motion[0].start)
        else $error("machine home start flags wrong");
    home_done_a: assert property (i_ce && q.ax[0].st == ASC_ST_RUN && i_move_done[0] && !halt[0]
        && !i_move_fault[0] && q.ax[0].mot.kind == ASC_MV_HOME_MACH
        |=> o_flags[0].home_done && !o_flags[0].home_req && o_flags[0].pos_done)
        else $error("machine home finish flags wrong");
    axis_err_a: assert property (i_ce && axis_err[0] |=> o_flags[0].err && !$rose(o_flags[0].busy))
        else $error("blocked start did not flag the axis");
    speed_clamp_a: assert property (i_ce && go[0] && kind == ASC_MV_JOG
        && {i_cmd.word[1], i_cmd.word[0]} > 32'h00030d40 |=> o_motion[0].speed == 32'h00030d40)
        else $error("jog speed not clamped");
    jog_no_done_a: assert property (i_ce && q.ax[0].st == ASC_ST_RUN && q.ax[0].mot.kind == ASC_MV_JOG
        && i_move_done[0] && !halt[0] && !i_move_fault[0] |=> !o_flags[0].busy && !o_flags[0].pos_done)
        else $error("jog end set positioning done");
    axis_apart_a: assert property (i_ce && go == 2'h1 && q.ax[1].st == ASC_ST_IDLE && !axis_err[1]
        |=> $stable(o_flags[1]))
        else $error("axis 0 start touched axis 1 flags");
    dual_index_a: assert property (i_ce && go == 2'h3
        |=> o_motion[1].data_index == $past(i_cmd.word[1]))
        else $error("dual start lost the axis 1 data number");
    fast_kind_a: assert property (i_ce && go[0] && i_cmd.op == ASC_OP_HOME && i_cmd.word[0] == 16'h0002
        |=> o_motion[0].kind == ASC_MV_HOME_FAST && o_motion[0].target == 32'h0)
        else $error("fast home to origin decoded wrongly");
    standby_addr_a: assert property (i_ce && go[0] && i_cmd.op == ASC_OP_HOME && i_cmd.word[0] == 16'h0003
        |=> o_motion[0].target == {$past(i_cmd.word[2]), $past(i_cmd.word[1])})
        else $error("standby address not taken");
    home_drop_a: assert property (i_ce && go[1] |=> !o_flags[1].home_done)
        else $error("start left home done set");
    fault_decel_a: assert property (i_ce && q.ax[0].st == ASC_ST_RUN && i_move_fault[0]
        |=> o_decel_req[0] && !o_flags[0].pos_done)
        else $error("fault did not decelerate cleanly");
    rest_clean_a: assert property (i_ce && q.ax[1].st == ASC_ST_DECEL && i_move_rest[1]
        |=> !o_flags[1].busy && !o_flags[1].pos_done && !o_flags[1].home_done)
        else $error("stopped move left a done flag set");
    fast_done_a: assert property (i_ce && q.ax[0].st == ASC_ST_RUN && i_move_done[0] && !halt[0]
        && !i_move_fault[0] && q.ax[0].mot.kind == ASC_MV_HOME_FAST
        |=> !o_flags[0].busy && o_flags[0].pos_done && !o_flags[0].home_done)
        else $error("fast home finish flags wrong");
    no_method_a: assert property (i_ce && i_cmd_valid && i_cmd.op == ASC_OP_HOME && i_cmd.loc_ok
        && i_pos_in_use[i_cmd.axis] && i_home_none[i_cmd.axis]
        |=> o_op_error && o_op_error_code == 16'h1014)
        else $error("home method none not reported");
    jog_params_a: assert property (i_ce && go[0] && kind == ASC_MV_JOG
        |=> o_motion[0].dir == $past(i_cmd.dir) && o_motion[0].acc == $past(i_cmd.word[2])
        && o_motion[0].dec == $past(i_cmd.word[3]))
        else $error("jog direction or times not taken");

    dual_start_c: cover property (i_ce && go == 2'h3);
    home_finish_c: cover property (o_flags[0].home_done && !o_flags[0].busy);
    decel_c: cover property (o_decel_req[0] ##1 !o_flags[0].busy);
    jog_start_c: cover property (i_ce && go[1] && kind == ASC_MV_JOG);

endmodule

`default_nettype wire

/* rtl/asc_defines.svh */
`ifndef ASC_DEFINES_SVH
`define ASC_DEFINES_SVH

// operation error codes (4100, 4101, 4116 decimal)
`define ASC_ERR_RANGE 16'h1004
`define ASC_ERR_LOC 16'h1005
`define ASC_ERR_UNUSED 16'h1014

// positioning data number span
`define ASC_DATA_MIN 16'h0001
`define ASC_DATA_MAX 16'h000a

// home return type codes
`define ASC_HOME_MACH 16'h0001
`define ASC_HOME_FAST_ORG 16'h0002
`define ASC_HOME_FAST_STBY 16'h0003

// jog speed limit in pulses per second (200000)
`define ASC_SPEED_MAX 32'h00030d40

// reset values
`define ASC_RST_CODE 16'h0000

`endif

/* rtl/asc_pkg.sv */
package asc_pkg;

    // command opcodes from the program side
    typedef enum logic [1:0] {
        ASC_OP_DUAL = 2'h0,
        ASC_OP_HOME = 2'h1,
        ASC_OP_JOG = 2'h2,
        ASC_OP_HALT = 2'h3
    } asc_op_e;

    // per-axis sequencer states
    typedef enum logic [2:0] {
        ASC_ST_IDLE = 3'b001,
        ASC_ST_RUN = 3'b010,
        ASC_ST_DECEL = 3'b100
    } asc_st_e;

    // kind of motion handed to the pulse generator
    typedef enum logic [1:0] {
        ASC_MV_TABLE = 2'h0,
        ASC_MV_HOME_MACH = 2'h1,
        ASC_MV_HOME_FAST = 2'h2,
        ASC_MV_JOG = 2'h3
    } asc_mv_e;

    // word[0..4] are consecutive control words following the start location
    typedef struct packed {
        asc_op_e op;
        logic axis;
        logic loc_ok;
        logic dir;
        logic [4:0][15:0] word;
    } asc_cmd_s;

    typedef struct packed {
        logic start;
        asc_mv_e kind;
        logic [15:0] data_index;
        logic [31:0] target;
        logic [31:0] speed;
        logic [15:0] acc;
        logic [15:0] dec;
        logic dir;
    } asc_motion_s;

    typedef struct packed {
        logic busy;
        logic pos_done;
        logic home_req;
        logic home_done;
        logic err;
    } asc_flags_s;

    typedef struct packed {
        asc_st_e st;
        asc_flags_s fl;
        asc_motion_s mot;
    } asc_axis_s;

    typedef struct packed {
        asc_axis_s [1:0] ax;
        logic op_err;
        logic [15:0] op_code;
    } asc_state_s;

endpackage

/* verif/asc_servo_model.sv */
`timescale 1ns/10ps
`default_nettype none

module asc_servo_model
    import asc_pkg::*;
(
    input wire logic i_ref_clk,
    input wire logic i_rst_b,
    input wire asc_motion_s [1:0] i_motion,
    input wire logic [1:0] i_decel_req,
    input wire logic [1:0][7:0] i_delay,
    input wire logic [1:0] i_fault,
    output logic [1:0] o_move_done,
    output logic [1:0] o_move_fault,
    output logic [1:0] o_move_rest
);
    logic [1:0][7:0] run_q;
    logic [1:0][1:0] rest_q;

    // a real amplifier stops counting once it is told to slow down
    always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            run_q <= '0;
            rest_q <= '0;
        end else begin
            for (int a = 0; a < 2; a++) begin
                if (i_decel_req[a]) begin
                    run_q[a] <= 8'h00;
                end else if (i_motion[a].start) begin
                    run_q[a] <= i_delay[a];
                end else if (run_q[a] != 8'h00) begin
                    run_q[a] <= run_q[a] - 8'h01;
                end
                rest_q[a] <= i_decel_req[a] ? ((rest_q[a] == 2'h3) ? 2'h3 : rest_q[a] + 2'h1) : 2'h0;
            end
        end
    end

    always_comb begin
        for (int a = 0; a < 2; a++) begin
            o_move_done[a] = (run_q[a] == 8'h01);
            o_move_fault[a] = i_fault[a] && (run_q[a] != 8'h00);
            o_move_rest[a] = i_decel_req[a] && (rest_q[a] == 2'h2);
        end
    end
endmodule

`default_nettype wire

/* verif/asc_start_unit_tb.sv */
`include "asc_defines.svh"
`timescale 1ns/10ps
`default_nettype none

module asc_start_unit_tb;
    import asc_pkg::*;
    logic i_ref_clk, i_rst_b, i_cmd_valid, i_err_clear, ce;
    asc_cmd_s i_cmd;
    logic [1:0] i_pos_in_use, i_home_none, fault, done, flt, rest, decel;
    logic [1:0][7:0] delay;
    asc_motion_s [1:0] mot;
    asc_flags_s [1:0] fl;
    logic op_err;
    logic [15:0] op_code;
    int errors, num_checks, cycles;

    asc_start_unit dut (.i_ref_clk(i_ref_clk), .i_rst_b(i_rst_b), .i_ce(ce),
        .i_cmd_valid(i_cmd_valid), .i_cmd(i_cmd), .i_pos_in_use(i_pos_in_use),
        .i_home_none(i_home_none), .i_move_done(done), .i_move_fault(flt), .i_move_rest(rest),
        .i_err_clear(i_err_clear), .o_motion(mot), .o_decel_req(decel), .o_flags(fl),
        .o_op_error(op_err), .o_op_error_code(op_code));
    asc_servo_model srv (.i_ref_clk(i_ref_clk), .i_rst_b(i_rst_b), .i_motion(mot),
        .i_decel_req(decel), .i_delay(delay), .i_fault(fault), .o_move_done(done),
        .o_move_fault(flt), .o_move_rest(rest));

    always #5 i_ref_clk = ~i_ref_clk;

    task automatic finish_test();
        if (errors == 0 && num_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    always @(posedge i_ref_clk) begin
        cycles++;
        if (cycles == 20000) begin
            errors++;
            $display("ERROR %0t: run did not end in time", $time);
            finish_test();
        end
    end

    task automatic chk_w(input logic [31:0] got, input logic [31:0] exp, input string what);
        num_checks++;
        if (got !== exp) begin
            errors++;
            $display("ERROR %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    task automatic chk_b(input logic got, input logic exp, input string what);
        num_checks++;
        if (got !== exp) begin
            errors++;
            $display("ERROR %0t: %s got %b expected %b", $time, what, got, exp);
        end
    endtask

    function automatic asc_cmd_s mk(asc_op_e op, logic ax, logic loc, logic d,
            logic [15:0] w0, logic [15:0] w1, logic [15:0] w2, logic [15:0] w3);
        asc_cmd_s c;
        c.op = op;
        c.axis = ax;
        c.loc_ok = loc;
        c.dir = d;
        c.word = {16'h0000, w3, w2, w1, w0};
        return c;
    endfunction

    // outputs of the taking edge are checked one step after it
    task automatic send(input asc_cmd_s c);
        @(posedge i_ref_clk);
        i_cmd_valid <= 1'b1;
        i_cmd <= c;
        @(posedge i_ref_clk);
        i_cmd_valid <= 1'b0;
        #1;
    endtask

    task automatic wait_idle(input int ax);
        int n;
        n = 0;
        while (fl[ax].busy !== 1'b0 && n < 300) begin
            @(posedge i_ref_clk);
            #1;
            n++;
        end
        chk_b(fl[ax].busy, 1'b0, "busy drop");
    endtask

    task automatic clear_err();
        @(posedge i_ref_clk);
        i_err_clear <= 1'b1;
        @(posedge i_ref_clk);
        i_err_clear <= 1'b0;
        #1;
        chk_b(op_err, 1'b0, "error clear");
    endtask

    task automatic t_dual();
        delay <= {8'h08, 8'h03};
        send(mk(ASC_OP_DUAL, 1'b0, 1'b1, 1'b0, 16'h0001, 16'h000a, 16'h0000, 16'h0000));
        for (int a = 0; a < 2; a++) begin
            chk_b(mot[a].start, 1'b1, "dual start");
            chk_b(fl[a].busy, 1'b1, "dual busy");
        end
        chk_w(32'(mot[0].data_index), 32'h1, "index0");
        chk_w(32'(mot[1].data_index), 32'ha, "index1");
        wait_idle(0);
        chk_b(fl[0].pos_done, 1'b1, "done0");
        chk_b(fl[1].busy, 1'b1, "busy1 kept");
        chk_b(fl[1].pos_done, 1'b0, "done1 early");
        wait_idle(1);
        chk_b(fl[1].pos_done, 1'b1, "done1");
        chk_b(fl[0].pos_done, 1'b1, "done0 held");
    endtask

    task automatic t_errors();
        asc_cmd_s c [4];
        logic [15:0] code [4];
        c[0] = mk(ASC_OP_DUAL, 1'b0, 1'b0, 1'b0, 16'h0001, 16'h0002, 16'h0000, 16'h0000);
        c[1] = mk(ASC_OP_DUAL, 1'b0, 1'b1, 1'b0, 16'h0001, 16'h0002, 16'h0000, 16'h0000);
        c[2] = mk(ASC_OP_DUAL, 1'b0, 1'b1, 1'b0, 16'h0000, 16'h0002, 16'h0000, 16'h0000);
        c[3] = mk(ASC_OP_DUAL, 1'b0, 1'b1, 1'b0, 16'h0001, 16'h000b, 16'h0000, 16'h0000);
        code = '{`ASC_ERR_LOC, `ASC_ERR_UNUSED, `ASC_ERR_RANGE, `ASC_ERR_RANGE};
        for (int i = 0; i < 4; i++) begin
            i_pos_in_use <= (i == 1) ? 2'h2 : 2'h3;
            send(c[i]);
            chk_b(op_err, 1'b1, "op error");
            chk_w(32'(op_code), 32'(code[i]), "op code");
            chk_b(fl[0].busy | fl[1].busy, 1'b0, "no start");
            if (i >= 2) begin
                chk_b(fl[i - 2].err, 1'b1, "axis err");
                chk_b(fl[3 - i].err, (i == 3), "other err");
            end
            clear_err();
        end
        i_pos_in_use <= 2'h3;
    endtask

    task automatic t_home();
        delay <= {8'h04, 8'h04};
        send(mk(ASC_OP_HOME, 1'b0, 1'b1, 1'b0, 16'h0001, 16'h0000, 16'h0000, 16'h0000));
        chk_b(fl[0].busy & fl[0].home_req, 1'b1, "home req");
        chk_b(fl[0].pos_done, 1'b0, "done cleared");
        chk_b(fl[0].err, 1'b0, "err cleared");
        wait_idle(0);
        chk_w(32'(fl[0]), 32'(5'b01010), "home finish");
        send(mk(ASC_OP_HOME, 1'b0, 1'b1, 1'b0, 16'h0003, 16'h5678, 16'h8000, 16'h0000));
        chk_b(fl[0].home_done, 1'b0, "home done cleared");
        chk_w(mot[0].target, 32'h80005678, "standby");
        chk_w(32'(mot[0].kind), 32'(ASC_MV_HOME_FAST), "fast kind");
        wait_idle(0);
        chk_b(fl[0].pos_done, 1'b1, "fast done");
        send(mk(ASC_OP_HOME, 1'b0, 1'b1, 1'b0, 16'h0002, 16'h5678, 16'h8000, 16'h0000));
        chk_w(mot[0].target, 32'h0, "standby ignored");
        wait_idle(0);
        send(mk(ASC_OP_HOME, 1'b0, 1'b1, 1'b0, 16'h0004, 16'h0000, 16'h0000, 16'h0000));
        chk_b(fl[0].err & ~fl[0].busy & ~op_err, 1'b1, "bad type");
        i_home_none <= 2'h2;
        send(mk(ASC_OP_HOME, 1'b1, 1'b1, 1'b0, 16'h0001, 16'h0000, 16'h0000, 16'h0000));
        chk_w(32'(op_code), 32'(`ASC_ERR_UNUSED), "no method");
        chk_b(fl[1].busy, 1'b0, "no method start");
        i_home_none <= 2'h0;
        clear_err();
    endtask

    task automatic t_halt();
        delay <= {8'h60, 8'h60};
        send(mk(ASC_OP_HOME, 1'b1, 1'b1, 1'b0, 16'h0001, 16'h0000, 16'h0000, 16'h0000));
        send(mk(ASC_OP_HALT, 1'b1, 1'b0, 1'b0, 16'h0000, 16'h0000, 16'h0000, 16'h0000));
        chk_b(decel[1], 1'b1, "decel");
        wait_idle(1);
        chk_b(fl[1].home_done | fl[1].pos_done | decel[1], 1'b0, "halted");
        send(mk(ASC_OP_HOME, 1'b0, 1'b1, 1'b0, 16'h0002, 16'h0000, 16'h0000, 16'h0000));
        fault <= 2'h1;
        repeat (3) @(posedge i_ref_clk);
        fault <= 2'h0;
        wait_idle(0);
        chk_b(fl[0].pos_done, 1'b0, "fault no done");
    endtask

    task automatic t_jog();
        delay <= {8'h05, 8'h05};
        send(mk(ASC_OP_JOG, 1'b0, 1'b1, 1'b1, 16'h93e0, 16'h0003, 16'h03e8, 16'h07d0));
        chk_b(mot[0].dir, 1'b1, "jog rev");
        chk_w(mot[0].speed, `ASC_SPEED_MAX, "jog clamp");
        chk_w({mot[0].acc, mot[0].dec}, 32'h03e807d0, "jog times");
        send(mk(ASC_OP_JOG, 1'b1, 1'b1, 1'b0, 16'h2710, 16'h0000, 16'h0001, 16'h0002));
        chk_b(mot[1].dir, 1'b0, "jog fwd");
        chk_w(mot[1].speed, 32'h00002710, "jog speed");
        wait_idle(0);
        wait_idle(1);
        chk_b(fl[0].pos_done | fl[1].pos_done, 1'b0, "jog no done");
    endtask

    // a command offered while the enable is low must not be taken
    task automatic t_freeze();
        @(posedge i_ref_clk);
        ce <= 1'b0;
        send(mk(ASC_OP_DUAL, 1'b0, 1'b1, 1'b0, 16'h0001, 16'h0002, 16'h0000, 16'h0000));
        chk_b(fl[0].busy | fl[1].busy, 1'b0, "frozen start");
        @(posedge i_ref_clk);
        ce <= 1'b1;
        @(posedge i_ref_clk);
    endtask

    initial begin
        i_ref_clk = 1'b0;
        i_rst_b = 1'b0;
        i_cmd_valid = 1'b0;
        i_cmd = '0;
        i_err_clear = 1'b0;
        ce = 1'b1;
        i_pos_in_use = 2'h3;
        i_home_none = 2'h0;
        fault = 2'h0;
        delay = '0;
        repeat (10) @(posedge i_ref_clk);
        i_rst_b <= 1'b1;
        repeat (3) @(posedge i_ref_clk);
        t_dual();
        t_errors();
        t_home();
        t_halt();
        t_jog();
        t_freeze();
        finish_test();
    end
endmodule

`default_nettype wire
